// ===== core/pc_stack_pkg.sv
// constants and types for the program counter and return stack block
package pc_stack_pkg;

  localparam int PC_W     = 21;
  localparam int SP_W     = 5;
  localparam int STK_LAST = 31;

  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST   = 21'h000000;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_TOP   = 5'h1F;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CNT_LOW  = 8'h00;
  localparam logic [7:0] OFS_HI_LATCH = 8'h04;
  localparam logic [7:0] OFS_UP_LATCH = 8'h08;
  localparam logic [7:0] OFS_STK_PTR  = 8'h0C;
  localparam logic [7:0] OFS_TOP_LOW  = 8'h10;
  localparam logic [7:0] OFS_TOP_HIGH = 8'h14;
  localparam logic [7:0] OFS_TOP_UP   = 8'h18;
  localparam logic [7:0] OFS_CTRL     = 8'h1C;

  localparam int FULL_BIT  = 7;
  localparam int UNF_BIT   = 6;
  localparam int OVR_BIT   = 0;
  localparam int EXT_BIT   = 1;

  localparam logic OVR_RST_DEFAULT = 1'b1;
  localparam logic EXT_SET_DEFAULT = 1'b0;

endpackage

// ===== core/program_counter_return_stack.sv
// program counter, address latches and 31-entry return stack with an AHB-Lite register port
`timescale 1ns/1ps
`default_nettype none

module program_counter_return_stack
  import pc_stack_pkg::*;
(
  input  wire  logic              ref_clk,         // core clock, 250 MHz
  input  wire  logic              rstn,            // power-on reset, active low, async
  input  wire  logic              clk_en,          // freezes all state while low
  input  wire  logic              sys_reset,       // non-power-on device reset, same clock
  input  wire  logic              seq_step,        // advance to next sequential instruction
  input  wire  logic              jump_load,       // absolute_jump or branch
  input  wire  logic [PC_W-1:0]   jump_target,     // target for jump_load
  input  wire  logic              call_push,       // call or relative_subroutine_jump
  input  wire  logic              irq_push,        // interrupt acknowledge
  input  wire  logic [PC_W-1:0]   call_target,     // target for call_push / irq_push
  input  wire  logic              ret_pop,         // return, exit_with_literal, interrupt_exit
  input  wire  logic              ext_exit_pop,    // extended_add_and_exit / extended_sub_and_exit
  input  wire  logic              sw_push,         // software push instruction
  input  wire  logic              sw_pop,          // software pop instruction
  input  wire  logic              hsel,            // AHB-Lite select
  input  wire  logic [31:0]       haddr,           // AHB-Lite address
  input  wire  logic [1:0]        htrans,          // AHB-Lite transfer type
  input  wire  logic              hwrite,          // AHB-Lite write
  input  wire  logic [2:0]        hsize,           // AHB-Lite size, word only
  input  wire  logic [31:0]       hwdata,          // AHB-Lite write data
  input  wire  logic              hready,          // AHB-Lite bus ready
  output logic                    hreadyout,       // AHB-Lite slave ready
  output logic [31:0]             hrdata,          // AHB-Lite read data
  output logic                    hresp,           // AHB-Lite response, always OKAY
  output logic [PC_W-1:0]         pc_out,          // current program counter
  output logic                    device_reset_req,// one-cycle pulse on stack overflow reset
  output logic                    stack_full_flag, // sticky full flag
  output logic                    stack_underflow_flag // sticky underflow flag
);

  typedef logic [STK_LAST:1][PC_W-1:0] stack_mem_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0]      hi_latch;
    logic [4:0]      up_latch;
    logic [SP_W-1:0] sp;
    logic            full;
    logic            unf;
    logic            ovr_rst_en;
    logic            ext_en;
    stack_mem_t      stk;
    logic            dp_wr;
    logic [7:0]      dp_ofs;
    logic [31:0]     rdata;
    logic            rst_req;
  } state_t;

  localparam state_t STATE_RST = '{
    pc:         PC_RST,
    hi_latch:   8'h00,
    up_latch:   5'h00,
    sp:         SP_EMPTY,
    full:       1'b0,
    unf:        1'b0,
    ovr_rst_en: OVR_RST_DEFAULT,
    ext_en:     EXT_SET_DEFAULT,
    stk:        '0,
    dp_wr:      1'b0,
    dp_ofs:     8'h00,
    rdata:      32'h00000000,
    rst_req:    1'b0
  };

  logic   rst_meta_q;
  logic   rst_sync_q;
  state_t s_q;
  state_t s_d;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // word alignment applied to every value entering the counter
  function automatic logic [PC_W-1:0] align(input logic [PC_W-1:0] v);
    return {v[PC_W-1:1], 1'b0};
  endfunction

  // push one value; handles both overflow policies
  function automatic state_t push_entry(input state_t s, input logic [PC_W-1:0] val);
    state_t          r;
    logic [SP_W-1:0] n;
    r = s;
    n = SP_W'(s.sp + 5'h01);
    if (s.sp == SP_TOP) begin
      r.full = 1'b1;
      if (s.ovr_rst_en) begin
        r.sp      = SP_EMPTY;
        r.rst_req = 1'b1;
      end
    end else begin
      r.sp = n;
      if (n == SP_TOP) begin
        r.full = 1'b1;
        if (s.ovr_rst_en) begin
          r.stk[n]  = align(PC_W'(val + PC_STEP));
          r.sp      = SP_EMPTY;
          r.rst_req = 1'b1;
        end else begin
          r.stk[n] = align(val);
        end
      end else begin
        r.stk[n] = align(val);
      end
    end
    return r;
  endfunction

  // pop into the counter; empty stack vectors to zero
  function automatic state_t pop_entry(input state_t s);
    state_t r;
    r = s;
    if (s.sp == SP_EMPTY) begin
      r.pc  = PC_RST;
      r.unf = 1'b1;
    end else begin
      r.pc = align(s.stk[s.sp]);
      r.sp = SP_W'(s.sp - 5'h01);
    end
    return r;
  endfunction

  // software discard: drop the top entry; an empty stack only raises underflow
  function automatic state_t drop_entry(input state_t s);
    state_t r;
    r = s;
    if (s.sp == SP_EMPTY) begin
      r.unf = 1'b1;
    end else begin
      r.sp = SP_W'(s.sp - 5'h01);
    end
    return r;
  endfunction

  // true for the three registers that reach the entry under the pointer
  function automatic logic is_top_ofs(input logic [7:0] o);
    return (o == OFS_TOP_LOW) || (o == OFS_TOP_HIGH) || (o == OFS_TOP_UP);
  endfunction

  // entry under the pointer; pointer zero has no storage, so it reads as zero
  function automatic logic [PC_W-1:0] top_of(input state_t s);
    logic [PC_W-1:0] v;
    v = PC_RST;
    if (s.sp != SP_EMPTY) begin
      v = s.stk[s.sp];
    end
    return v;
  endfunction

  // flag write: a zero clears, a one is ignored, a hardware set this cycle wins
  function automatic logic flag_after_write(input logic cur, input logic wbit, input logic hw_set);
    logic f;
    f = cur;
    if (!wbit && !hw_set) begin
      f = 1'b0;
    end
    return f;
  endfunction

  // a low byte read hands the counter's two upper bytes to the latches
  function automatic state_t copy_to_latches(input state_t s, input logic [PC_W-1:0] pc);
    state_t r;
    r = s;
    r.hi_latch = pc[15:8];
    r.up_latch = pc[20:16];
    return r;
  endfunction

  // a low byte write pulls both latches into the counter on the same edge
  function automatic logic [PC_W-1:0] load_low(input state_t s, input logic [7:0] lo);
    return align({s.up_latch, s.hi_latch, lo});
  endfunction

  // read value of one register
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] ofs);
    logic [PC_W-1:0] top;
    logic [31:0]     w;
    top = top_of(s);
    w   = 32'h00000000;
    if (ofs == OFS_CNT_LOW) begin
      w[7:0] = s.pc[7:0];
    end else if (ofs == OFS_HI_LATCH) begin
      w[7:0] = s.hi_latch;
    end else if (ofs == OFS_UP_LATCH) begin
      w[4:0] = s.up_latch;
    end else if (ofs == OFS_STK_PTR) begin
      w[FULL_BIT] = s.full;
      w[UNF_BIT]  = s.unf;
      w[4:0]      = s.sp;
    end else if (ofs == OFS_TOP_LOW) begin
      w[7:0] = top[7:0];
    end else if (ofs == OFS_TOP_HIGH) begin
      w[7:0] = top[15:8];
    end else if (ofs == OFS_TOP_UP) begin
      w[4:0] = top[20:16];
    end else if (ofs == OFS_CTRL) begin
      w[OVR_BIT] = s.ovr_rst_en;
      w[EXT_BIT] = s.ext_en;
    end
    return w;
  endfunction

  logic            addr_ok;
  logic            take;
  logic            do_pop;
  logic            set_full;
  logic            set_unf;
  logic [7:0]      ofs;
  logic [PC_W-1:0] top_val;

  assign ofs     = haddr[7:0];
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  // address phase accepted only while clocked; otherwise the master is stalled
  assign take    = hsel && hready && htrans[1] && clk_en;
  assign do_pop  = ret_pop || (ext_exit_pop && s_q.ext_en);

  always_comb begin
    s_d         = s_q;
    s_d.rst_req = 1'b0;
    s_d.dp_wr   = 1'b0;
    top_val     = PC_RST;
    set_full    = 1'b0;
    set_unf     = 1'b0;

    // core sequencing; latches are touched here only by sys_reset, which clears them
    if (sys_reset) begin
      s_d.pc       = PC_RST;
      s_d.sp       = SP_EMPTY;
      s_d.hi_latch = 8'h00;
      s_d.up_latch = 5'h00;
    end else if (do_pop) begin
      s_d = pop_entry(s_d);
    end else if (call_push || irq_push) begin
      s_d    = push_entry(s_d, s_q.pc);
      s_d.pc = align(call_target);
    end else if (sw_push) begin
      s_d = push_entry(s_d, s_q.pc);
    end else if (sw_pop) begin
      s_d = drop_entry(s_d);
    end else if (jump_load) begin
      s_d.pc = align(jump_target);
    end else if (seq_step) begin
      s_d.pc = align(PC_W'(s_q.pc + PC_STEP));
    end
    set_full = s_d.full && !s_q.full;
    set_unf  = s_d.unf && !s_q.unf;

    // address phase: capture read data and latch side effect of the low byte read
    if (take) begin
      s_d.dp_wr  = hwrite && addr_ok;
      s_d.dp_ofs = ofs;
      s_d.rdata  = (addr_ok && !hwrite) ? read_word(s_q, ofs) : 32'h00000000;
      if (!hwrite && addr_ok && ofs == OFS_CNT_LOW) begin
        s_d = copy_to_latches(s_d, s_q.pc);
      end
    end

    // data phase write; software edits override the core op of the same cycle, except a flag that the core op sets
    if (s_q.dp_wr) begin
      top_val = top_of(s_d);
      if (s_q.dp_ofs == OFS_CNT_LOW) begin
        s_d.pc = load_low(s_d, hwdata[7:0]);
      end else if (s_q.dp_ofs == OFS_HI_LATCH) begin
        s_d.hi_latch = hwdata[7:0];
      end else if (s_q.dp_ofs == OFS_UP_LATCH) begin
        s_d.up_latch = hwdata[4:0];
      end else if (s_q.dp_ofs == OFS_STK_PTR) begin
        s_d.sp = hwdata[4:0];
        s_d.full = flag_after_write(s_d.full, hwdata[FULL_BIT], set_full);
        s_d.unf  = flag_after_write(s_d.unf, hwdata[UNF_BIT], set_unf);
      end else if (s_q.dp_ofs == OFS_TOP_LOW) begin
        top_val[7:0] = hwdata[7:0];
      end else if (s_q.dp_ofs == OFS_TOP_HIGH) begin
        top_val[15:8] = hwdata[7:0];
      end else if (s_q.dp_ofs == OFS_TOP_UP) begin
        top_val[20:16] = hwdata[4:0];
      end else if (s_q.dp_ofs == OFS_CTRL) begin
        s_d.ovr_rst_en = hwdata[OVR_BIT];
        s_d.ext_en     = hwdata[EXT_BIT];
      end
      // pointer zero has no storage, so top writes there are dropped
      if (s_d.sp != SP_EMPTY && is_top_ofs(s_q.dp_ofs)) begin
        s_d.stk[s_d.sp] = top_val;
      end
    end
  end

  // flags survive sys_reset; only the power-on reset or a zero written to the pointer register clears them
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= STATE_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign hreadyout            = clk_en;
  assign hresp                = 1'b0;
  assign hrdata               = s_q.rdata;
  assign pc_out               = s_q.pc;
  assign device_reset_req     = s_q.rst_req;
  assign stack_full_flag      = s_q.full;
  assign stack_underflow_flag = s_q.unf;

  // hsize is accepted but only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = ^hsize;

endmodule

`default_nettype wire

// ===== tb/pcrs_checker.sv
// assertions on the counter and return stack ports
`timescale 1ns/1ps
`default_nettype none
module pcrs_checker
  import pc_stack_pkg::*;
(
  input wire logic            ref_clk, rstn, clk_en, sys_reset, seq_step, jump_load,
  input wire logic            call_push, irq_push, ret_pop, ext_exit_pop, sw_push, sw_pop,
  input wire logic            hsel, hwrite, hreadyout, device_reset_req,
  input wire logic            stack_full_flag, stack_underflow_flag,
  input wire logic [1:0]      htrans,
  input wire logic [PC_W-1:0] jump_target, call_target, pc_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic wr_q;
  logic hold;
  // a bus write lands one cycle late and may move any field, so it masks the core checks
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) wr_q <= 1'b0;
    else wr_q <= hsel & hreadyout & htrans[1] & hwrite;
  assign hold = sys_reset | ret_pop | ext_exit_pop | wr_q | !clk_en;
  property p_step;
    seq_step & !(hold | call_push | irq_push | sw_push | sw_pop | jump_load) |=> pc_out == $past(pc_out) + PC_STEP;
  endproperty
  a_step: assert property (p_step) else $error("step not plus two");
  property p_jump;
    jump_load & !(hold | call_push | irq_push | sw_push | sw_pop) |=> pc_out == {$past(jump_target[PC_W-1:1]), 1'b0};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_call;
    call_push & !(hold | stack_full_flag) |=> pc_out == {$past(call_target[PC_W-1:1]), 1'b0};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_lsb;
    pc_out[0] == 1'b0;
  endproperty
  a_lsb: assert property (p_lsb) else $error("counter lsb set");
  property p_pulse;
    device_reset_req |=> !device_reset_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset request too long");
  property p_rst_full;
    device_reset_req |-> stack_full_flag;
  endproperty
  a_rst_full: assert property (p_rst_full) else $error("reset without full");
  property p_full;
    stack_full_flag & !wr_q |=> stack_full_flag;
  endproperty
  a_full: assert property (p_full) else $error("full flag lost");
  property p_unf;
    stack_underflow_flag & !wr_q |=> stack_underflow_flag;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow flag lost");
  property p_unf_pc;
    $rose(stack_underflow_flag) & $past(ret_pop) |-> pc_out == PC_RST;
  endproperty
  a_unf_pc: assert property (p_unf_pc) else $error("empty pop not zero");
  c_rst: cover property (device_reset_req);
  c_unf: cover property ($rose(stack_underflow_flag));
  c_full: cover property ($rose(stack_full_flag));
endmodule
`default_nettype wire

// ===== tb/decoder_model.sv
// stand-in for the instruction decoder and interrupt acknowledge logic
`timescale 1ns/1ps
`default_nettype none
module decoder_model
  import pc_stack_pkg::*;
(
  input  wire logic            ref_clk, // core clock
  output logic      [8:0]      stb,     // one-hot strobes, bit 8 is device reset
  output logic      [PC_W-1:0] tgt      // jump or call target
);
  initial begin
    stb = '0;
    tgt = '0;
  end
  // one strobe per op, released after one edge so ops never merge
  task automatic op(input int k, input logic [PC_W-1:0] t);
    @(posedge ref_clk);
    stb <= 9'h001 << k;
    tgt <= t;
    @(posedge ref_clk);
    stb <= '0;
    tgt <= ~t;
  endtask
endmodule
`default_nettype wire

// ===== tb/program_counter_return_stack_test.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module program_counter_return_stack_test import pc_stack_pkg::*;;
  typedef struct {logic [31:0] e; logic [1:0] src; string nm;} note_t;
  logic hresp_o, rreq_o, full_o, unf_o;
  note_t q[$];
  logic ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic dph_rd = 1'b0, pc_look = 1'b0, hreadyout;
  logic [31:0] haddr = '0, hwdata = '0, seed = 32'h8DE8, hrdata;
  logic [1:0] htrans = '0;
  logic [8:0] stb;
  logic [PC_W-1:0] tgt, pc, p, t, pc_out;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  decoder_model i_dec (.ref_clk(ref_clk), .stb(stb), .tgt(tgt));
  program_counter_return_stack i_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .sys_reset(stb[8]), .seq_step(stb[0]), .jump_load(stb[1]), .jump_target(tgt),
    .call_push(stb[2]), .irq_push(stb[3]), .call_target(tgt), .ret_pop(stb[4]),
    .ext_exit_pop(stb[5]), .sw_push(stb[6]), .sw_pop(stb[7]), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp_o), .pc_out(pc_out), .device_reset_req(rreq_o),
    .stack_full_flag(full_o), .stack_underflow_flag(unf_o));
  function automatic logic [PC_W-1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[PC_W-1:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
    do @(posedge ref_clk); while (!hreadyout);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; dph_rd <= !w;
    do @(posedge ref_clk); while (!hreadyout);
    dph_rd <= 1'b0; hwdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    q.push_back('{e, 2'h0, nm});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pcx(input logic [PC_W-1:0] e);
    q.push_back('{{11'h0, e}, 2'h1, "pc_out"});
    pc_look <= 1'b1;
    @(posedge ref_clk);
    pc_look <= 1'b0;
  endtask
  // flags as {hresp, reset request, full, underflow}
  task automatic flg(input logic [3:0] e);
    q.push_back('{{28'h0, e}, 2'h2, "flags"});
    pc_look <= 1'b1;
    @(posedge ref_clk);
    pc_look <= 1'b0;
  endtask
  // the observer owns the comparison; drivers only leave notes
  always @(posedge ref_clk) begin
    note_t n;
    if (dph_rd | pc_look) begin
      n = q.pop_front();
      chk(n.nm, n.src == 2'h1 ? {11'h0, pc_out} :
          n.src == 2'h2 ? {28'h0, hresp_o, rreq_o, full_o, unf_o} : hrdata, n.e);
    end
  end
  task automatic results();
    $display("counts: %0d compared, %0d failed", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(OFS_STK_PTR, 32'h0, "ptr");
    rd(OFS_CTRL, 32'h1, "ctrl");
    pcx(PC_RST);
    t = rnd();
    i_dec.op(1, t); pc = {t[PC_W-1:1], 1'b0}; pcx(pc);
    i_dec.op(0, 0); pc += PC_STEP; pcx(pc);
    clk_en <= 1'b0;
    i_dec.op(0, 0); pcx(pc);
    clk_en <= 1'b1;
    $display("test counter done");
    t = rnd();
    bus(1'b1, OFS_HI_LATCH, {24'h0, t[15:8]});
    bus(1'b1, OFS_UP_LATCH, {27'h0, t[20:16]});
    bus(1'b1, OFS_CNT_LOW, {24'h0, t[7:0]});
    pc = {t[PC_W-1:1], 1'b0}; pcx(pc);
    i_dec.op(1, ~t); pc = {~t[PC_W-1:1], 1'b0};
    rd(OFS_CNT_LOW, {24'h0, pc[7:0]}, "low byte");
    rd(OFS_HI_LATCH, {24'h0, pc[15:8]}, "high latch");
    rd(OFS_UP_LATCH, {27'h0, pc[20:16]}, "upper latch");
    $display("test latches done");
    t = rnd(); i_dec.op(2, t);
    rd(OFS_STK_PTR, 32'h1, "ptr");
    rd(OFS_TOP_UP, {27'h0, pc[20:16]}, "top upper");
    bus(1'b1, OFS_TOP_LOW, 32'h5A); pc[7:0] = 8'h5A;
    i_dec.op(4, 0); pcx(pc);
    rd(OFS_HI_LATCH, {24'h0, pc[15:8]}, "high latch");
    i_dec.op(3, t); i_dec.op(5, 0); pcx({t[PC_W-1:1], 1'b0});
    bus(1'b1, OFS_CTRL, 32'h3);
    i_dec.op(5, 0); pcx(pc);
    $display("test calls done");
    i_dec.op(6, 0); rd(OFS_TOP_LOW, {24'h0, pc[7:0]}, "top low");
    i_dec.op(7, 0); rd(OFS_STK_PTR, 32'h0, "ptr");
    i_dec.op(4, 0); pc = PC_RST; pcx(pc);
    flg(4'h1);
    rd(OFS_STK_PTR, 32'h40, "ptr");
    rd(OFS_CTRL, 32'h3, "ctrl");
    bus(1'b1, OFS_STK_PTR, 32'hC0); rd(OFS_STK_PTR, 32'h40, "ptr");
    bus(1'b1, OFS_STK_PTR, 32'h0); rd(OFS_STK_PTR, 32'h0, "ptr");
    $display("test underflow done");
    bus(1'b1, OFS_CTRL, 32'h2);
    repeat (31) begin
      t = rnd(); p = pc; i_dec.op(2, t); pc = {t[PC_W-1:1], 1'b0};
    end
    i_dec.op(6, 0);
    flg(4'h2);
    rd(OFS_STK_PTR, 32'h9F, "ptr");
    rd(OFS_TOP_LOW, {24'h0, p[7:0]}, "top low");
    bus(1'b1, OFS_CTRL, 32'h1); bus(1'b1, OFS_STK_PTR, 32'h1E);
    i_dec.op(6, 0); flg(4'h6);
    rd(OFS_STK_PTR, 32'h80, "ptr");
    bus(1'b1, OFS_STK_PTR, 32'h9F);
    rd(OFS_TOP_LOW, {24'h0, pc[7:0] + 8'h2}, "top low");
    i_dec.op(8, 0); pcx(PC_RST);
    rd(OFS_STK_PTR, 32'h80, "ptr");
    $display("test overflow done");
    results();
  end
endmodule
bind program_counter_return_stack pcrs_checker i_chk (.ref_clk, .rstn, .clk_en, .sys_reset,
  .seq_step, .jump_load, .call_push, .irq_push, .ret_pop, .ext_exit_pop, .sw_push, .sw_pop,
  .hsel, .hwrite, .hreadyout, .device_reset_req, .stack_full_flag, .stack_underflow_flag,
  .htrans, .jump_target, .call_target, .pc_out);
`default_nettype wire
